//--- design/spm_protection_ctrl.sv
// Protection mode controller: latched-off and auto-restart decisions.
// Assumes comparator and pin indications arrive asynchronously from the
// analog front end; each passes a two-stage synchroniser first.
// All times are counts of the system clock; the package converts them.
// The analog levels live in the comparators; this block sees only their
// outputs, so every threshold here is a time, never a voltage.
//
// Summary of operation
// - Supply above overvoltage level for 120 us latches the device off.
// - Overvoltage protection stays armed in normal and burst operation.
// - Latched off: reference mostly off; exit only when supply below 6.23V.
// - Latched off: lockout turns startup cell on below 10.5V, off above 18V.
// - Latched off: no startup or switching when lockout turn-on level reached.
// - Junction over thermal shutdown threshold latches the device off.
// - Over-temperature and overvoltage pass a 25 us spike filter first.
// - Normally the current limit comparator ends the switching pulse.
// - Current sense above short level for 190 ns latches off at once.
// - External transistor pulling blanking pin low forces latched off.
// - External latch request ignored during startup for 2 ms.
// - Feedback overload for 20 ms releases the blanking pin clamp.
// - Counter done and pin above threshold, after 25 us, start restart.
// - Without capacitor the pin threshold holds right after clamp release.
// - Supply undervoltage enters auto-restart and a fresh startup.
// - Auto-restart always runs startup, rechecks faults, then resumes.
`timescale 1ns/1ps
module spm_protection_ctrl
	import spm_pkg::*;
#(
	parameter int OVL_BLANK   = OVL_BLANK_CYC,
	parameter int EXT_BLANK   = EXT_BLANK_CYC,
	parameter int STARTUP_CYC = 100
) (
	input  wire logic      clk_sys,
	input  wire logic      srst,
	input  wire logic      supply_overvoltage_comparator,
	input  wire logic      thermal_shutdown_hot,
	input  wire logic      current_limit_comparator,
	input  wire logic      secondary_short_comparator,
	input  wire logic      blanking_pin_low,
	input  wire logic      blanking_pin_high,
	input  wire logic      feedback_overload_comparator,
	input  wire logic      supply_below_reset,
	input  wire logic      supply_below_off,
	input  wire logic      supply_above_on,
	input  wire logic      pwm_pulse_request,
	output logic           gate_drive,
	output logic           startup_cell_on,
	output logic           reference_on,
	output logic           blanking_clamp_switch,
	output logic           latched_off,
	output logic           auto_restart
);
	import spm_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; the first stage feeds only the second
	localparam int NIN = 11;
	logic [NIN-1:0] sync_a;
	logic [NIN-1:0] sync_b;
	logic [NIN-1:0] next_sync_a;
	logic [NIN-1:0] next_sync_b;

	// Both stages load every edge; one bit per indication, no spare
	always_comb begin
		next_sync_a = {
			supply_overvoltage_comparator,
			thermal_shutdown_hot,
			current_limit_comparator,
			secondary_short_comparator,
			blanking_pin_low,
			blanking_pin_high,
			feedback_overload_comparator,
			supply_below_reset,
			supply_below_off,
			supply_above_on,
			pwm_pulse_request
		};
		next_sync_b = sync_a;
	end

	// Synchroniser flops; no reset, they flush within two edges
	always_ff @(posedge clk_sys) begin
		sync_a <= next_sync_a;
		sync_b <= next_sync_b;
	end

	logic s_ovp;
	logic s_hot;
	logic s_ilim;
	logic s_short;
	logic s_bl_low;
	logic s_bl_high;
	logic s_ovl;
	logic s_uv_reset;
	logic s_uv_off;
	logic s_uv_on;
	logic s_pwm;

	// Second stage outputs, the only taps the logic below may read
	assign {
		s_ovp,
		s_hot,
		s_ilim,
		s_short,
		s_bl_low,
		s_bl_high,
		s_ovl,
		s_uv_reset,
		s_uv_off,
		s_uv_on,
		s_pwm
	} = sync_b;

	// Saturating persistence counter step: count while cond, else clear.
	// Saturation keeps a long fault from wrapping back under the limit.
	function automatic logic [CNT_W-1:0] persist(
		input logic             cond,
		input logic [CNT_W-1:0] cnt,
		input int               lim
	);
		if (!cond)
			return '0;
		else if (int'(cnt) >= lim)
			return cnt;
		else
			return cnt + 1'b1;
	endfunction

	// Filter verdict, shared by every persistence and blanking counter
	function automatic logic reached(
		input logic [CNT_W-1:0] cnt,
		input int               lim
	);
		return int'(cnt) >= lim;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Fault persistence filters and blanking counters
	logic [CNT_W-1:0] ovp_cnt;
	logic [CNT_W-1:0] hot_cnt;
	logic [CNT_W-1:0] short_cnt;
	logic [CNT_W-1:0] ovl_cnt;
	logic [CNT_W-1:0] rst_cnt;
	logic [CNT_W-1:0] ext_cnt;
	logic [CNT_W-1:0] next_ovp_cnt;
	logic [CNT_W-1:0] next_hot_cnt;
	logic [CNT_W-1:0] next_short_cnt;
	logic [CNT_W-1:0] next_ovl_cnt;
	logic [CNT_W-1:0] next_rst_cnt;
	logic [CNT_W-1:0] next_ext_cnt;
	spm_mode_t        mode;
	logic             running;
	logic             ovl_done;
	logic             ovp_trip;
	logic             hot_trip;
	logic             short_trip;
	logic             ext_trip;
	logic             restart_and_gate;
	logic             restart_trip;

	// Running covers startup and normal; burst is part of normal here
	// Faults are armed only here; outside it the gate is already off
	assign running = (mode == SPM_STARTUP) || (mode == SPM_NORMAL);

	always_comb begin
		// OVP: spike filter then 120 us persistence, armed while running
		next_ovp_cnt   = persist(s_ovp && running, ovp_cnt,
			SPIKE_FILTER_CYC + OVP_PERSIST_CYC);
		next_hot_cnt   = persist(s_hot && running, hot_cnt,
			SPIKE_FILTER_CYC);
		next_short_cnt = persist(s_short && running, short_cnt,
			SHORT_PERSIST_CYC);
		// Overload blanking: dropping feedback clears the count
		next_ovl_cnt   = persist(s_ovl && running, ovl_cnt, OVL_BLANK);
		// Restart gate spike filter after clamp release
		next_rst_cnt   = persist(restart_and_gate, rst_cnt,
			SPIKE_FILTER_CYC);
		// External latch blanking counts from startup entry into normal
		// operation, so a startup shorter than the blanking cannot disarm it
		if (running)
			next_ext_cnt = persist(1'b1, ext_cnt, EXT_BLANK);
		else
			next_ext_cnt = '0;
	end

	// Filter and blanking counters start cleared
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ovp_cnt   <= '0;
			hot_cnt   <= '0;
			short_cnt <= '0;
			ovl_cnt   <= '0;
			rst_cnt   <= '0;
			ext_cnt   <= '0;
		end else begin
			ovp_cnt   <= next_ovp_cnt;
			hot_cnt   <= next_hot_cnt;
			short_cnt <= next_short_cnt;
			ovl_cnt   <= next_ovl_cnt;
			rst_cnt   <= next_rst_cnt;
			ext_cnt   <= next_ext_cnt;
		end
	end

	// Trip decisions from the filters
	assign ovp_trip   = reached(ovp_cnt,
		SPIKE_FILTER_CYC + OVP_PERSIST_CYC);
	assign hot_trip   = reached(hot_cnt, SPIKE_FILTER_CYC);
	assign short_trip = reached(short_cnt, SHORT_PERSIST_CYC);
	// Pin pulled under the clamp level means the external transistor;
	// the blanking keeps an unsettled pin at startup from latching
	assign ext_trip   = running && s_bl_low
		&& reached(ext_cnt, EXT_BLANK);
	// Basic blanking done; the clamp opens from here
	assign ovl_done   = reached(ovl_cnt, OVL_BLANK);
	// No capacitor: high indication arrives right after release
	assign restart_and_gate = ovl_done && s_bl_high && running;
	// Overload auto-restart only after the gate held for the spike filter
	assign restart_trip = reached(rst_cnt, SPIKE_FILTER_CYC);

	////////////////////////////////////////////////////////////////////////
	// Mode machine
	logic [CNT_W-1:0] su_cnt;
	logic [CNT_W-1:0] next_su_cnt;
	spm_mode_t        next_mode;
	logic             any_latch;

	// Every latching cause; each is already filtered to its own time
	assign any_latch = ovp_trip
		|| hot_trip
		|| short_trip
		|| ext_trip;

	// Next mode from the present mode and the filtered causes
	always_comb begin
		next_mode   = mode;
		next_su_cnt = '0;
		unique case (mode)
			SPM_OFF: begin
				if (s_uv_on)
					next_mode = SPM_STARTUP;
			end
			SPM_STARTUP: begin
				// Fixed startup phase with switching, then recheck
				next_su_cnt = su_cnt + 1'b1;
				if (int'(su_cnt) >= STARTUP_CYC - 1)
					next_mode = SPM_NORMAL;
			end
			SPM_NORMAL: begin
			end
			SPM_RESTART: begin
				// Switching stops, so the rail sags to the lockout level;
				// only once the cell has recharged it past turn-on does a
				// fresh startup begin, otherwise an overload would retry
				// at once with no pause
				if (s_uv_on && startup_cell_on)
					next_mode = SPM_STARTUP;
			end
			SPM_LATCHED: begin
				// Only supply collapse leaves this state
				if (s_uv_reset)
					next_mode = SPM_OFF;
			end
			default: begin
				// Unused codes of the mode register fall back to off
				next_mode = SPM_OFF;
			end
		endcase
		// Latching faults take priority over restart causes; both are
		// judged only while switching, since latched and restart modes
		// already hold the gate off and must not re-enter themselves
		if (running && any_latch)
			next_mode = SPM_LATCHED;
		else if (running && (s_uv_off || restart_trip))
			next_mode = SPM_RESTART;
	end

	// Mode register; reset starts in off with the cell charging
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mode   <= SPM_OFF;
			su_cnt <= '0;
		end else begin
			mode   <= next_mode;
			su_cnt <= next_su_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs; every port comes straight from a flip-flop so
	// the pins never glitch while the next mode settles
	logic next_gate;
	logic next_cell;
	logic next_ref;
	logic next_clamp;
	logic next_latch;
	logic next_restart;
	logic cell_on;

	always_comb begin
		// Pulse ends as soon as the current limit trips
		next_gate  = (next_mode == SPM_STARTUP || next_mode == SPM_NORMAL)
			&& s_pwm && !s_ilim && !any_latch;
		// Lockout hysteresis drives the startup cell in every mode
		// between the two levels the cell keeps its last state
		if (s_uv_off)
			next_cell = 1'b1;
		else if (s_uv_on)
			next_cell = 1'b0;
		else
			next_cell = cell_on;
		// Reference stays down while latched it also stays down
		// in off, where the supply has not yet reached turn-on
		next_ref   = next_mode != SPM_LATCHED && next_mode != SPM_OFF;
		// Clamp released only once blanking completes
		next_clamp = !(ovl_done && running);
		// Mode flags follow the next mode so they change with it
		next_latch   = next_mode == SPM_LATCHED;
		next_restart = next_mode == SPM_RESTART;
	end

	// Output flops; reset leaves the cell charging and the clamp closed
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gate_drive            <= 1'b0;
			cell_on               <= 1'b1;
			startup_cell_on       <= 1'b1;
			reference_on          <= 1'b0;
			blanking_clamp_switch <= 1'b1;
			latched_off           <= 1'b0;
			auto_restart          <= 1'b0;
		end else begin
			gate_drive            <= next_gate;
			cell_on               <= next_cell;
			startup_cell_on       <= next_cell;
			reference_on          <= next_ref;
			blanking_clamp_switch <= next_clamp;
			latched_off           <= next_latch;
			auto_restart          <= next_restart;
		end
	end
endmodule

//--- design/spm_pkg.sv
// Package for the supply protection mode controller.
// Assumes a single 10 MHz system clock; all times become cycle counts here.
package spm_pkg;
	// System clock rate
	localparam int CLK_HZ = 10_000_000;

	// Times as printed, in their own units
	localparam int OVP_PERSIST_US   = 120;
	localparam int SPIKE_FILTER_US  = 25;
	localparam int SHORT_PERSIST_NS = 190;
	localparam int EXT_BLANK_MS     = 2;
	localparam int OVL_BLANK_MS     = 20;

	// Cycle counts; least times round up, none below one cycle
	localparam int OVP_PERSIST_CYC   = (OVP_PERSIST_US * (CLK_HZ / 1000) + 999)
		/ 1000;
	localparam int SPIKE_FILTER_CYC  = (SPIKE_FILTER_US * (CLK_HZ / 1000) + 999)
		/ 1000;
	localparam int SHORT_PERSIST_CYC = (SHORT_PERSIST_NS * (CLK_HZ / 1_000_000)
		+ 999) / 1000;
	localparam int EXT_BLANK_CYC     = EXT_BLANK_MS * (CLK_HZ / 1000);
	localparam int OVL_BLANK_CYC     = OVL_BLANK_MS * (CLK_HZ / 1000);

	// Counter width wide enough for every count above
	localparam int CNT_W = 18;

	// Operating modes
	typedef enum logic [2:0] {
		SPM_OFF,
		SPM_STARTUP,
		SPM_NORMAL,
		SPM_RESTART,
		SPM_LATCHED
	} spm_mode_t;
endpackage

//--- test/spm_supply_model.sv
// Supply rail, power stage and blanking pin as the controller sees them.
// Assumes one clock; supply kept in centivolts, moving 10 per cycle, 50 while collapsing.
`timescale 1ns/1ps
module spm_supply_model (
	input  wire logic clk_sys,
	input  wire logic startup_cell_on,
	input  wire logic gate_drive,
	input  wire logic aux_ok,
	input  wire logic collapse,
	input  wire logic ext_latch_req,
	input  wire logic blanking_clamp_switch,
	output logic      supply_below_reset,
	output logic      supply_below_off,
	output logic      supply_above_on,
	output logic      blanking_pin_low,
	output logic      blanking_pin_high
);
	int vcc = 0;
	// Cell charges; aux winding holds the rail only while switching
	always @(posedge clk_sys) begin
		if (collapse)
			vcc <= (vcc > 50) ? vcc - 50 : 0;
		else if (startup_cell_on)
			vcc <= vcc + 10;
		else if (!(gate_drive && aux_ok) && vcc > 0)
			vcc <= vcc - 10;
	end
	// Lockout and latch reset comparators
	assign supply_below_reset = vcc < 623;
	assign supply_below_off   = vcc < 1050;
	assign supply_above_on    = vcc > 1800;
	// No capacitor: the pin passes 4.0V as soon as the clamp opens
	assign blanking_pin_low  = ext_latch_req;
	assign blanking_pin_high = !blanking_clamp_switch && !ext_latch_req;
endmodule

//--- test/spm_protection_ctrl_props.sv
// Checker for the protection mode controller, bound to its ports.
// Assumes inputs reach the mode logic two to four edges after a change.
`timescale 1ns/1ps
module spm_protection_ctrl_props #(
	parameter int OVL_BLANK = spm_pkg::OVL_BLANK_CYC
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic thermal_shutdown_hot,
	input wire logic secondary_short_comparator,
	input wire logic feedback_overload_comparator,
	input wire logic supply_below_reset,
	input wire logic supply_below_off,
	input wire logic supply_above_on,
	input wire logic gate_drive,
	input wire logic startup_cell_on,
	input wire logic reference_on,
	input wire logic blanking_clamp_switch,
	input wire logic latched_off,
	input wire logic auto_restart
);
	logic [17:0] hot_cnt;
	logic [17:0] fb_cnt;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	// Run lengths of the thermal and overload inputs
	always_ff @(posedge clk_sys) begin
		hot_cnt <= (srst || !thermal_shutdown_hot) ? '0 : hot_cnt + 1'b1;
		fb_cnt <= (srst || !feedback_overload_comparator) ? '0 : fb_cnt + 1'b1;
	end
	a_latch_exit: assert property ($fell(latched_off) |->
		$past(supply_below_reset, 2) || $past(supply_below_reset, 3)
		|| $past(supply_below_reset, 4)) else $error("latch left early");
	a_latch_ref_off: assert property (latched_off && $past(latched_off)
		|-> !reference_on) else $error("reference on while latched");
	a_latch_no_gate: assert property (latched_off && $past(latched_off)
		|-> !gate_drive) else $error("gate on while latched");
	a_uvlo_cell_on: assert property (latched_off && supply_below_off
		&& !supply_below_reset |-> ##[1:5] (startup_cell_on || !latched_off))
		else $error("cell not on below lockout");
	a_uvlo_cell_off: assert property (latched_off && supply_above_on
		|-> ##[1:5] (!startup_cell_on || !latched_off))
		else $error("cell not off above turn-on");
	a_short_latch: assert property (reference_on && !auto_restart
		&& secondary_short_comparator [*6] |-> ##[0:2] latched_off)
		else $error("short not latched");
	a_hot_latch: assert property (hot_cnt == 18'h00106 && reference_on
		&& !auto_restart |-> latched_off) else $error("thermal not latched");
	a_hot_filter: assert property ($rose(latched_off) |->
		hot_cnt == 0 || hot_cnt >= 250) else $error("thermal spike latched");
	a_clamp_early: assert property (fb_cnt != 0 && fb_cnt < OVL_BLANK
		|-> blanking_clamp_switch) else $error("clamp released early");
	a_clamp_release: assert property (fb_cnt == OVL_BLANK + 6
		&& reference_on && !auto_restart |-> !blanking_clamp_switch)
		else $error("clamp not released");
	a_uv_restart: assert property (supply_below_off && reference_on
		&& !latched_off && !supply_below_reset
		|-> ##[1:5] (auto_restart || latched_off)) else $error("no restart");
	a_restart_start: assert property ($fell(auto_restart)
		|-> reference_on && !startup_cell_on && !latched_off)
		else $error("restart without startup");
	c_latch: cover property ($rose(latched_off));
	c_restart: cover property ($rose(auto_restart));
	c_release: cover property ($fell(blanking_clamp_switch));
endmodule

//--- test/tb_spm_protection_ctrl.sv
// Self-checking bench for the protection mode controller.
// Assumes the supply model and checker files are compiled before this one.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_spm_protection_ctrl;
	localparam int OB = 50;
	logic clk_sys = 0, srst = 1, pwm_pulse_request = 1, aux_ok = 1;
	logic supply_overvoltage_comparator = 0, thermal_shutdown_hot = 0;
	logic current_limit_comparator = 0, secondary_short_comparator = 0;
	logic feedback_overload_comparator = 0, collapse = 0, ext_latch_req = 0;
	logic blanking_pin_low, blanking_pin_high, supply_below_reset;
	logic supply_below_off, supply_above_on, gate_drive, startup_cell_on;
	logic reference_on, blanking_clamp_switch, latched_off, auto_restart;
	int num_errors = 0;
	int total_checks = 0;
	always #50 clk_sys = ~clk_sys;
	spm_supply_model u_spm_supply_model (.clk_sys, .startup_cell_on,
		.gate_drive, .aux_ok, .collapse, .ext_latch_req, .blanking_clamp_switch,
		.supply_below_reset, .supply_below_off, .supply_above_on,
		.blanking_pin_low, .blanking_pin_high);
	spm_protection_ctrl #(.OVL_BLANK(OB), .EXT_BLANK(20), .STARTUP_CYC(10))
		u_spm_protection_ctrl (.clk_sys, .srst, .supply_overvoltage_comparator,
		.thermal_shutdown_hot, .current_limit_comparator,
		.secondary_short_comparator, .blanking_pin_low, .blanking_pin_high,
		.feedback_overload_comparator, .supply_below_reset, .supply_below_off,
		.supply_above_on, .pwm_pulse_request, .gate_drive, .startup_cell_on,
		.reference_on, .blanking_clamp_switch, .latched_off, .auto_restart);
	////////////////////////////////////////////////////////////////////////
	// Shared helpers: waits are bounded, a spent bound ends the run
	function automatic logic pick(input int k);
		case (k)
			0: return latched_off;
			1: return auto_restart;
			2: return startup_cell_on;
			4: return blanking_clamp_switch;
			default: return reference_on;
		endcase
	endfunction
	task automatic idle(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic wt(input int k, input logic v, input int lim);
		int i;
		for (i = 0; i < lim && pick(k) !== v; i++) @(negedge clk_sys);
		if (i == lim) begin
			`CHK("wait bound", 1'b1, 1'b0)
			print_verdict();
		end
	endtask
	task automatic done(input string s);
		$display("test %s finished", s);
	endtask
	// Collapse the rail, recharge it and see switching come back
	task automatic power_up();
		collapse = 1;
		idle(60);
		collapse = 0;
		wt(5, 1'b1, 400);
		idle(20);
		`CHK("switching", 1'b1, gate_drive)
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_limit();
		pwm_pulse_request = 0;
		idle(6);
		`CHK("no request", 1'b0, gate_drive)
		pwm_pulse_request = 1;
		current_limit_comparator = 1;
		idle(6);
		`CHK("pulse ended", 1'b0, gate_drive)
		current_limit_comparator = 0;
		idle(6);
		`CHK("pulse back", 1'b1, gate_drive)
		done("limit");
	endtask
	task automatic t_short();
		secondary_short_comparator = 1;
		idle(8);
		secondary_short_comparator = 0;
		`CHK("short latch", 1'b1, latched_off)
		`CHK("ref off", 1'b0, reference_on)
		wt(2, 1'b1, 200);
		wt(2, 1'b0, 200);
		`CHK("still latched", 1'b1, latched_off)
		`CHK("no gate", 1'b0, gate_drive)
		collapse = 1;
		wt(0, 1'b0, 100);
		power_up();
		done("short");
	endtask
	task automatic t_thermal();
		thermal_shutdown_hot = 1;
		idle(200);
		thermal_shutdown_hot = 0;
		idle(10);
		`CHK("spike ignored", 1'b0, latched_off)
		thermal_shutdown_hot = 1;
		idle(245);
		`CHK("filtered", 1'b0, latched_off)
		wt(0, 1'b1, 20);
		thermal_shutdown_hot = 0;
		power_up();
		done("thermal");
	endtask
	task automatic t_ovp();
		supply_overvoltage_comparator = 1;
		idle(1400);
		`CHK("ovp early", 1'b0, latched_off)
		wt(0, 1'b1, 80);
		supply_overvoltage_comparator = 0;
		power_up();
		done("overvoltage");
	endtask
	task automatic t_ext();
		collapse = 1;
		idle(60);
		`CHK("uv restart", 1'b1, auto_restart)
		ext_latch_req = 1;
		collapse = 0;
		wt(1, 1'b0, 400);
		idle(12);
		`CHK("ext blanked", 1'b0, latched_off)
		wt(0, 1'b1, 30);
		ext_latch_req = 0;
		power_up();
		done("external");
	endtask
	task automatic t_overload();
		feedback_overload_comparator = 1;
		idle(OB - 10);
		feedback_overload_comparator = 0;
		idle(10);
		`CHK("re-clamped", 1'b1, blanking_clamp_switch)
		`CHK("no restart", 1'b0, auto_restart)
		feedback_overload_comparator = 1;
		wt(4, 1'b0, OB + 10);
		idle(240);
		`CHK("restart filter", 1'b0, auto_restart)
		wt(1, 1'b1, 30);
		feedback_overload_comparator = 0;
		wt(1, 1'b0, 400);
		idle(20);
		`CHK("resumed", 1'b1, gate_drive)
		done("overload");
	endtask
	task automatic t_uv();
		aux_ok = 0;
		wt(1, 1'b1, 200);
		aux_ok = 1;
		wt(1, 1'b0, 400);
		idle(20);
		`CHK("ref back", 1'b1, reference_on)
		`CHK("switching back", 1'b1, gate_drive)
		done("undervoltage");
	endtask
	// Closing report and the single end of the run
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence: reset held for 16 cycles, then every scenario
	initial begin
		repeat (16) @(posedge clk_sys);
		@(negedge clk_sys);
		srst = 0;
		power_up();
		t_limit();
		t_short();
		t_thermal();
		t_ovp();
		t_ext();
		t_overload();
		t_uv();
		print_verdict();
	end
endmodule
bind spm_protection_ctrl spm_protection_ctrl_props #(.OVL_BLANK(OVL_BLANK))
	u_props (.clk_sys, .srst, .thermal_shutdown_hot,
	.secondary_short_comparator, .feedback_overload_comparator,
	.supply_below_reset, .supply_below_off, .supply_above_on, .gate_drive,
	.startup_cell_on, .reference_on, .blanking_clamp_switch, .latched_off,
	.auto_restart);
